// File: overflow_timer.sv
// overflow_timer: 8-bit overflow counter with shared prescaler, apb regs
// assumes one pclk cycle per instruction cycle and synchronous inputs
//
// Overview of operation
// (RULE1) eight-bit up-counter, one step per cycle without prescaler
// (RULE2) one prescaler shared with watchdog; owner bit 3, ratio bits 2..0
// (RULE3) watchdog owns prescaler gives 1:1; else ratios 1:2 to 1:256
// (RULE4) counter value read and written by software at index 01h
// (RULE5) after a counter write, no counting for the next two cycles
// (RULE6) rollover from ffh to 00h sets overflow flag, requests interrupt
// (RULE7) request suppressed while enable bit 5 of interrupt control is clear
// (RULE8) flag stays set until software clears it before re-enabling
// (RULE9) counter stops during sleep, so no overflow wake from sleep
// (RULE10) counter write clears prescaler count while timer owns prescaler
// (RULE11) watchdog clear instruction clears prescaler while watchdog owns it
// (RULE12) prescaler count is never visible or writable through registers
// (RULE13) flag sets on every rollover; enable gates only the request
// (RULE14) counter wraps from maximum to zero and keeps counting
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module overflow_timer #(
  parameter int unsigned PRESCALE_W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // core side
  input wire logic sleep_mode,
  input wire logic watchdog_tick,
  input wire logic watchdog_clear_instruction,
  output logic watchdog_count_tick,
  // interrupt
  output logic irq
);

  // register state
  logic [7:0] timer_q;
  logic [7:0] timer_d;
  overflow_timer_pkg::option_type option_q;
  overflow_timer_pkg::option_type option_d;
  logic flag_q;
  logic flag_d;
  logic en_q;
  logic en_d;
  logic [1:0] hold_q;
  logic [1:0] hold_d;
  logic irq_q;
  logic wdt_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  function automatic logic reg_hit(input logic [11:0] a,
                                   input logic [11:0] t);
    reg_hit = (a == t);
  endfunction : reg_hit

  // bus phases
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_q;
  wire wr = access & pwrite & pstrb[0];
  wire [7:0] wbyte = pwdata[7:0];

  // address decode
  wire hit_tmr = reg_hit(paddr, overflow_timer_pkg::addr_timer); // RULE4
  wire hit_opt = reg_hit(paddr, overflow_timer_pkg::addr_option);
  wire hit_int = reg_hit(paddr, overflow_timer_pkg::addr_interrupt_control_register);
  wire hit_sts = reg_hit(paddr, overflow_timer_pkg::addr_status);
  wire hit_clr = reg_hit(paddr, overflow_timer_pkg::addr_clear);
  wire hit_en = reg_hit(paddr, overflow_timer_pkg::addr_enable);
  // prescaler count has no address on purpose
  wire mapped = hit_tmr | hit_opt | hit_int | hit_sts | hit_clr |
                hit_en; // RULE12

  wire tmr_wr = wr & hit_tmr; // RULE4
  wire opt_wr = wr & hit_opt;
  wire int_wr = wr & hit_int;
  wire clr_wr = wr & hit_clr;
  wire en_wr = wr & hit_en;

  // read data
  wire [7:0] interrupt_control_register_view = {2'b00, en_q, 2'b00, flag_q, 2'b00};
  wire [31:0] rd_sel = hit_tmr ? {24'h000000, timer_q} :
                       hit_opt ? {24'h000000, option_q} :
                       hit_int ? {24'h000000, interrupt_control_register_view} :
                       hit_sts ? {31'h00000000, flag_q} :
                       hit_en ? {31'h00000000, en_q} :
                       32'h00000000;

  // prescaler ownership and steering
  wire owner_wdt = option_q.owner_wdt; // RULE2
  wire pre_tick_in = owner_wdt ? watchdog_tick : ~sleep_mode; // RULE2
  wire pre_clear = owner_wdt ? watchdog_clear_instruction :
                   tmr_wr; // RULE10 RULE11
  wire pre_tick_out;
  wire [PRESCALE_W-1:0] pre_count;

  ratio_prescaler #(
    .WIDTH(PRESCALE_W)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(pre_tick_in),
    .clear(pre_clear),
    .ratio(option_q.ratio),
    .tick_out(pre_tick_out),
    .count(pre_count)
  );

  // counting
  wire rate_tick = owner_wdt ? 1'b1 : pre_tick_out; // RULE3
  wire hold_free = (hold_q == 2'h0);
  // sleep freezes the count, so it cannot overflow while asleep
  wire inc = rate_tick & hold_free & ~sleep_mode &
             ~tmr_wr; // RULE1 RULE5 RULE9
  wire ovf = inc & (timer_q == 8'hff); // RULE6

  assign timer_d = tmr_wr ? wbyte :
                   (inc ? timer_q + 8'h01 : timer_q); // RULE1 RULE14
  // written value stands for two cycles; software can pre-compensate
  assign hold_d = tmr_wr ? overflow_timer_pkg::write_hold_cycles :
                  (hold_free ? hold_q : hold_q - 2'h1); // RULE5
  assign option_d = opt_wr ? overflow_timer_pkg::option_type'(wbyte) :
                    option_q;

  // flag: hardware set wins over any same-cycle software clear
  wire flag_clr = (int_wr & ~wbyte[overflow_timer_pkg::flag_bit]) |
                  (clr_wr & wbyte[overflow_timer_pkg::status_ovf_bit]);
  assign flag_d = ovf | (flag_q & ~flag_clr); // RULE6 RULE8 RULE13
  assign en_d = int_wr ? wbyte[overflow_timer_pkg::irq_enable_bit] :
                (en_wr ? wbyte[overflow_timer_pkg::status_ovf_bit] : en_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_q <= overflow_timer_pkg::timer_reset;
      option_q <= overflow_timer_pkg::option_type'(
                    overflow_timer_pkg::option_reset);
      hold_q <= 2'h0;
      flag_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      timer_q <= timer_d;
      option_q <= option_d;
      hold_q <= hold_d;
      flag_q <= flag_d;
      en_q <= en_d;
    end
  end

  // outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      wdt_q <= 1'b0;
    end else begin
      irq_q <= flag_d & en_d; // RULE7 RULE13
      // watchdog sees the raw tick when the timer holds the prescaler
      wdt_q <= owner_wdt ? pre_tick_out : watchdog_tick; // RULE2
    end
  end

  // zero-wait slave: data captured in setup, ready in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        prdata_q <= rd_sel;
      end
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
  assign irq = irq_q;
  assign watchdog_count_tick = wdt_q;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_one_to_one;
    (owner_wdt && hold_free && !sleep_mode && !tmr_wr)
      |=> timer_q == $past(timer_q) + 8'h01;
  endproperty
  a_one_to_one: assert property (p_one_to_one) // RULE1
    else $error("timer did not step at 1:1");

  property p_no_step_without_tick;
    (!owner_wdt && !pre_tick_out && !tmr_wr) |=> $stable(timer_q);
  endproperty
  a_no_step_without_tick: assert property (p_no_step_without_tick) // RULE3
    else $error("timer stepped without prescaler output");

  property p_ratio_two;
    (!owner_wdt && option_q.ratio == 3'h0 && pre_tick_out)
      |-> pre_count[0];
  endproperty
  a_ratio_two: assert property (p_ratio_two) // RULE2
    else $error("1:2 ratio fired on even count");

  property p_write_hold;
    tmr_wr ##1 !tmr_wr ##1 !tmr_wr |-> timer_q == $past(wbyte, 2);
  endproperty
  a_write_hold: assert property (p_write_hold) // RULE5
    else $error("timer moved within two cycles of a write");

  property p_overflow_flag;
    (inc && timer_q == 8'hff) |=> flag_q && timer_q == 8'h00;
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) // RULE6
    else $error("rollover did not set flag or wrap to zero");

  property p_masked;
    !en_q |-> !irq_q;
  endproperty
  a_masked: assert property (p_masked) // RULE7
    else $error("interrupt raised while disabled");

  property p_irq_follows;
    (flag_q && en_q) |-> irq_q;
  endproperty
  a_irq_follows: assert property (p_irq_follows) // RULE13
    else $error("enabled flag did not raise interrupt");

  property p_sticky;
    (flag_q && !int_wr && !clr_wr) |=> flag_q;
  endproperty
  a_sticky: assert property (p_sticky) // RULE8
    else $error("flag dropped without software clear");

  property p_sleep_freeze;
    (sleep_mode && !tmr_wr) |=> $stable(timer_q) && !$rose(flag_q);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze) // RULE9
    else $error("timer advanced during sleep");

  property p_pre_clear_timer;
    (tmr_wr && !owner_wdt) |=> pre_count == '0;
  endproperty
  a_pre_clear_timer: assert property (p_pre_clear_timer) // RULE10
    else $error("counter write left prescaler count");

  property p_pre_clear_wdt;
    (watchdog_clear_instruction && owner_wdt && !opt_wr)
      |=> pre_count == '0;
  endproperty
  a_pre_clear_wdt: assert property (p_pre_clear_wdt) // RULE11
    else $error("watchdog clear left prescaler count");

  property p_unmapped;
    (setup && !mapped) |=> pslverr_q && pready_q && prdata_q == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) // RULE12
    else $error("unmapped access not refused");

  property p_ready_pulse;
    setup |=> pready_q;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) // RULE4
    else $error("setup not answered in the next cycle");

  property p_read_timer;
    (setup && hit_tmr) |=> prdata_q == {24'h000000, $past(timer_q)};
  endproperty
  a_read_timer: assert property (p_read_timer) // RULE4
    else $error("counter read returned a stale value");

  property p_timer_write;
    tmr_wr |=> timer_q == $past(wbyte);
  endproperty
  a_timer_write: assert property (p_timer_write) // RULE4
    else $error("counter write did not land");

  property p_hold_blocks;
    (!hold_free && !tmr_wr) |=> $stable(timer_q);
  endproperty
  a_hold_blocks: assert property (p_hold_blocks) // RULE5
    else $error("timer stepped inside the write hold");

  property p_no_false_flag;
    (!flag_q && !ovf) |=> !flag_q;
  endproperty
  a_no_false_flag: assert property (p_no_false_flag) // RULE6
    else $error("flag set without a rollover");

  property p_enable_alias;
    en_wr |=> en_q == $past(wbyte[overflow_timer_pkg::status_ovf_bit]);
  endproperty
  a_enable_alias: assert property (p_enable_alias) // RULE7
    else $error("enable register write did not land");

  property p_clear_works;
    (clr_wr && wbyte[overflow_timer_pkg::status_ovf_bit] && !ovf)
      |=> !flag_q;
  endproperty
  a_clear_works: assert property (p_clear_works) // RULE8
    else $error("clear register write left the flag set");

  property p_masked_flag;
    (ovf && !en_q) |=> flag_q;
  endproperty
  a_masked_flag: assert property (p_masked_flag) // RULE13
    else $error("masked rollover did not set the flag");

  property p_wrap_on;
    (ovf ##1 (owner_wdt && hold_free && !sleep_mode && !tmr_wr))
      |=> timer_q == 8'h01;
  endproperty
  a_wrap_on: assert property (p_wrap_on) // RULE14
    else $error("counter stopped after wrapping");

  property p_option_write;
    opt_wr |=> option_q == $past(wbyte);
  endproperty
  a_option_write: assert property (p_option_write) // RULE2
    else $error("option write did not land");

  property p_wdt_owned;
    owner_wdt |=> wdt_q == $past(pre_tick_out);
  endproperty
  a_wdt_owned: assert property (p_wdt_owned) // RULE2
    else $error("watchdog tick not taken from prescaler");

  property p_wdt_raw;
    !owner_wdt |=> wdt_q == $past(watchdog_tick);
  endproperty
  a_wdt_raw: assert property (p_wdt_raw) // RULE2
    else $error("raw watchdog tick not passed through");

  c_overflow: cover property (inc && timer_q == 8'hff ##1 irq_q);
  c_write_then_count: cover property (tmr_wr ##3 inc);
  c_prescaled_step: cover property (!owner_wdt && pre_tick_out && inc);
  c_flag_clear: cover property (flag_q && clr_wr ##1 !flag_q);

endmodule : overflow_timer
`default_nettype wire

// File: overflow_timer_bench.sv
// self-checking bench for the overflow timer block
// assumes apb slave answers with pready; bench drives every port itself
`timescale 1ns/100ps
`default_nettype none
module overflow_timer_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic sleep_mode = 1'b0;
  logic watchdog_tick = 1'b0;
  logic watchdog_clear_instruction = 1'b0;
  logic pready, pslverr, watchdog_count_tick, irq;
  logic [31:0] prdata;
  logic [34:0] exp_q[$];
  logic [34:0] e;
  logic [7:0] last = 8'h00;
  logic [7:0] n;
  int err_count = 0;
  int n_tests = 0;
  int tick_cnt = 0;
  int c0;

  overflow_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .watchdog_tick(watchdog_tick),
    .watchdog_clear_instruction(watchdog_clear_instruction),
    .watchdog_count_tick(watchdog_count_tick), .irq(irq));

  always #20 pclk = ~pclk;

  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    n_tests++;
    if (g !== x) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  // mode 00 absolute, 10 record only, 11 delta from last read
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      e = exp_q.pop_front();
      if (e[34:33] == 2'b11) chk({25'h0, prdata[7:0] - last}, e[32:0]);
      else if (e[34:33] == 2'b00) chk({pslverr, prdata}, e[32:0]);
      last = prdata[7:0];
    end
    if (watchdog_count_tick === 1'b1) tick_cnt++;
  end

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [34:0] x);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(x);
    @(posedge pclk);
    penable <= 1'b1;
    // no wait bound here: the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // two counter reads whose setup edges lie k cycles apart
  task automatic pair(input int k, input logic [7:0] dl);
    apb(1'b0, overflow_timer_pkg::addr_timer, 32'h0, {2'b10, 33'h0});
    repeat (k - 3) @(posedge pclk);
    apb(1'b0, overflow_timer_pkg::addr_timer, 32'h0, {3'b110, 24'h0, dl});
  endtask : pair

  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    apb(1'b0, a, 32'h0, {2'b00, x});
  endtask : rd

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  initial begin
    repeat (10000) @(posedge pclk);
    err_count++;
    final_report();
  end

  initial begin
    void'($urandom(55));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(overflow_timer_pkg::addr_option, {1'b0, 32'hff});
    rd(overflow_timer_pkg::addr_status, 33'h0);
    rd(12'h100, {1'b1, 32'h0});
    apb(1'b1, overflow_timer_pkg::addr_interrupt_control_register, 32'h20, 35'h0);
    $display("test reset and map done");
    // values kept low so no rollover sneaks in here
    repeat (3) begin
      n = 8'($urandom % 240);
      apb(1'b1, overflow_timer_pkg::addr_timer, {24'h0, n}, 35'h0);
      rd(overflow_timer_pkg::addr_timer, {25'h0, n});
      rd(overflow_timer_pkg::addr_timer, {25'h0, n + 8'h02});
    end
    rd(overflow_timer_pkg::addr_status, 33'h0);
    chk({32'h0, irq}, 33'h0);
    $display("test write hold done");
    apb(1'b1, overflow_timer_pkg::addr_timer, 32'hff, 35'h0);
    rd(overflow_timer_pkg::addr_timer, 33'hff);
    rd(overflow_timer_pkg::addr_timer, 33'h01);
    rd(overflow_timer_pkg::addr_status, 33'h1);
    rd(overflow_timer_pkg::addr_interrupt_control_register, 33'h24);
    chk({32'h0, irq}, 33'h1);
    apb(1'b1, overflow_timer_pkg::addr_clear, 32'h1, 35'h0);
    rd(overflow_timer_pkg::addr_status, 33'h0);
    chk({32'h0, irq}, 33'h0);
    $display("test overflow irq done");
    apb(1'b1, overflow_timer_pkg::addr_enable, 32'h0, 35'h0);
    apb(1'b1, overflow_timer_pkg::addr_timer, 32'hff, 35'h0);
    repeat (8) @(posedge pclk);
    rd(overflow_timer_pkg::addr_status, 33'h1);
    chk({32'h0, irq}, 33'h0);
    apb(1'b1, overflow_timer_pkg::addr_interrupt_control_register, 32'h0, 35'h0);
    rd(overflow_timer_pkg::addr_status, 33'h0);
    // byte lane 0 off: the write must be dropped
    pstrb <= 4'he;
    apb(1'b1, overflow_timer_pkg::addr_interrupt_control_register, 32'h20, 35'h0);
    pstrb <= 4'hf;
    rd(overflow_timer_pkg::addr_interrupt_control_register, 33'h0);
    $display("test masked overflow done");
    sleep_mode <= 1'b1;
    pair(4, 8'h00);
    sleep_mode <= 1'b0;
    pair(4, 8'h04);
    $display("test sleep done");
    for (int r = 0; r < 8; r++) begin
      apb(1'b1, overflow_timer_pkg::addr_option, r, 35'h0);
      pair(1 << (r + 2), 8'h02);
    end
    $display("test ratios done");
    // timer owns prescaler, so raw watchdog ticks pass through
    c0 = tick_cnt;
    @(posedge pclk) watchdog_clear_instruction <= 1'b1;
    @(posedge pclk) watchdog_clear_instruction <= 1'b0;
    repeat (3) begin
      @(posedge pclk) watchdog_tick <= 1'b1;
      @(posedge pclk) watchdog_tick <= 1'b0;
    end
    repeat (4) @(posedge pclk);
    chk(33'(tick_cnt - c0), 33'h3);
    // watchdog owns prescaler at 1:2; clear, then three ticks give one
    apb(1'b1, overflow_timer_pkg::addr_option, 32'h08, 35'h0);
    c0 = tick_cnt;
    @(posedge pclk) watchdog_clear_instruction <= 1'b1;
    @(posedge pclk) watchdog_clear_instruction <= 1'b0;
    repeat (3) begin
      @(posedge pclk) watchdog_tick <= 1'b1;
      @(posedge pclk) watchdog_tick <= 1'b0;
    end
    repeat (4) @(posedge pclk);
    chk(33'(tick_cnt - c0), 33'h1);
    $display("test watchdog path done");
    final_report();
  end
endmodule : overflow_timer_bench
`default_nettype wire

// File: overflow_timer_pkg.sv
// constants and carrier types for the overflow timer block
// assumes an apb slave with 32-bit data and byte addresses
package overflow_timer_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [9:0] idx_timer_count_value = 10'h001;
  localparam logic [9:0] idx_option = 10'h081;
  localparam logic [9:0] idx_interrupt_control_register = 10'h00b;
  localparam logic [9:0] idx_irq_status = 10'h010;
  localparam logic [9:0] idx_irq_clear = 10'h011;
  localparam logic [9:0] idx_irq_enable = 10'h012;

  localparam int unsigned addr_w = 12;
  localparam logic [11:0] addr_timer = {idx_timer_count_value, 2'b00};
  localparam logic [11:0] addr_option = {idx_option, 2'b00};
  localparam logic [11:0] addr_interrupt_control_register =
    {idx_interrupt_control_register, 2'b00};
  localparam logic [11:0] addr_status = {idx_irq_status, 2'b00};
  localparam logic [11:0] addr_clear = {idx_irq_clear, 2'b00};
  localparam logic [11:0] addr_enable = {idx_irq_enable, 2'b00};

  // field positions
  localparam int unsigned owner_bit = 3;
  localparam int unsigned ratio_lsb = 0;
  localparam int unsigned ratio_w = 3;
  localparam int unsigned irq_enable_bit = 5;
  localparam int unsigned flag_bit = 2;
  localparam int unsigned status_ovf_bit = 0;

  // reset values
  localparam logic [7:0] option_reset = 8'hff;
  localparam logic [7:0] timer_reset = 8'h00;

  // timing counts, in instruction cycles
  localparam logic [1:0] write_hold_cycles = 2'h2;

  typedef struct packed {
    logic [3:0] upper;
    logic owner_wdt;
    logic [2:0] ratio;
  } option_type;

endpackage : overflow_timer_pkg

// File: ratio_prescaler.sv
// shared 8-bit prescaler with power-of-two output ratio
// assumes tick_in and clear are one-cycle pulses on pclk
`timescale 1ns/100ps
`default_nettype none
module ratio_prescaler #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // count control
  input wire logic tick_in,
  input wire logic clear,
  input wire logic [2:0] ratio,
  // result
  output logic tick_out,
  output logic [WIDTH-1:0] count
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  wire [WIDTH-1:0] mask;

  // ratio n divides by two to the n plus one
  assign mask = ~({WIDTH{1'b1}} << ({1'b0, ratio} + 4'h1));
  assign tick_out = tick_in & ~clear & ((count_q & mask) == mask);
  // clear wins: a write restarts the ratio from zero
  assign count_d = clear ? '0 : (tick_in ? count_q + WIDTH'(1) : count_q);
  assign count = count_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule : ratio_prescaler
`default_nettype wire
